// [hw/regx_regs.vh]
// Constants for the expanded register store controller
`ifndef REGX_REGS_VH
`define REGX_REGS_VH
`define RX_WORD_BITS    4
`define RX_A_BITS       7
`define RX_BC_BITS      6
`define RX_CHIP_LO      4
`define RX_A_CHIPS      8
`define RX_BC_CHIPS     4
`define RX_ROM_CHIP     3'h3
`define RX_HALF_CYC     4'hC
`define RX_SETTLE_CYC   4'h1
`define RX_CNT_W        4
`endif

// [hw/chip_decoder.v]
// One-hot active-low chip select decoder with enable
`timescale 1ns/1ps
`default_nettype none
module chip_decoder #(
    parameter SEL_W = 2,
    parameter OUT_N = 4
) (
    input  wire             clk_sys,
    input  wire             rst,
    input  wire             en,
    input  wire [SEL_W-1:0] sel,
    output reg  [OUT_N-1:0] sel_n_r
);
    genvar i;
    generate
        for (i = 0; i < OUT_N; i = i + 1) begin : g_dec
            always @(posedge clk_sys) begin
                if (rst) begin
                    sel_n_r[i] <= 1'b1;
                end else begin
                    sel_n_r[i] <= ~(en && (sel == i));
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// [hw/phase_gen.v]
// Divider producing the cycle phase and its edge pulses
`timescale 1ns/1ps
`default_nettype none
`include "regx_regs.vh"
module phase_gen (
    input  wire clk_sys,
    input  wire rst,
    input  wire run,
    output reg  phase_hi_r,
    output reg  fall_pulse_r,
    output reg  rise_pulse_r
);
    reg [`RX_CNT_W-1:0] cnt_r;
    always @(posedge clk_sys) begin
        if (rst) begin
            cnt_r        <= {`RX_CNT_W{1'b0}};
            phase_hi_r   <= 1'b1;
            fall_pulse_r <= 1'b0;
            rise_pulse_r <= 1'b0;
        end else begin
            fall_pulse_r <= 1'b0;
            rise_pulse_r <= 1'b0;
            if (!run) begin
                cnt_r      <= {`RX_CNT_W{1'b0}};
                phase_hi_r <= 1'b1;
            end else if (cnt_r == `RX_HALF_CYC - 4'h1) begin
                cnt_r        <= {`RX_CNT_W{1'b0}};
                phase_hi_r   <= ~phase_hi_r;
                fall_pulse_r <= phase_hi_r;
                rise_pulse_r <= ~phase_hi_r;
            end else begin
                cnt_r <= cnt_r + 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

// [hw/regx_ctrl.v]
// Controller sequencing the expanded register store
`timescale 1ns/1ps
`default_nettype none
`include "regx_regs.vh"
// Operation
// - A low bits address word in every chip; upper A bits pick one output enable.
// - A word feeds R operand; constant ROM answers to B field, never to C write enable.
// - B low bits address source; B bits four and five enable chip onto S.
// - C low bits address destination; C bits four and five pick write enable.
// - Clock high drives source address and holds instruction enable high.
// - Source data comes from chip output or slice port per B decoder.
// - Falling edge latches source data, then address switches to destination.
// - Instruction enable goes low only after destination address settles.
// - Two-address mode uses destination equal to source in all six bits.
// - Each slice holds forty-eight writable and sixteen read-only words.
module regx_ctrl (
    input  wire                    clk_sys,
    input  wire                    rst,
    input  wire                    start,
    input  wire                    two_addr,
    input  wire [`RX_A_BITS-1:0]   a_field,
    input  wire [`RX_BC_BITS-1:0]  b_field,
    input  wire [`RX_BC_BITS-1:0]  c_field,
    input  wire                    slice_write_n,
    output reg                     busy_r,
    output reg                     done_r,
    output reg                     phase_out_r,
    output reg  [`RX_WORD_BITS-1:0] a_word_r,
    output reg  [`RX_A_CHIPS-1:0]  a_oe_n_r,
    output reg  [`RX_WORD_BITS-1:0] ram_addr_r,
    output reg  [`RX_BC_CHIPS-1:0] b_oe_n_r,
    output reg                     src_latch_r,
    output reg                     instr_enable_low_r,
    output reg  [`RX_BC_CHIPS-1:0] c_we_n_r
);
    // ****************************************
    // States and holding registers
    // ****************************************
    localparam ST_IDLE = 4'b0001;
    localparam ST_SRC  = 4'b0010;
    localparam ST_DST  = 4'b0100;
    localparam ST_WR   = 4'b1000;

    reg [3:0]                state_r;
    reg [3:0]                state_nxt;
    reg [`RX_A_BITS-1:0]     a_r;
    reg [`RX_BC_BITS-1:0]    b_r;
    reg [`RX_BC_BITS-1:0]    c_r;
    reg [`RX_CNT_W-1:0]      settle_r;
    reg                      wr_s1_r;
    reg                      wr_s2_r;
    wire                     phase_hi;
    wire                     fall_p;
    wire                     rise_p;
    wire [`RX_BC_CHIPS-1:0]  we_dec_n;
    wire [`RX_A_CHIPS-1:0]   a_dec_n;
    wire [`RX_BC_CHIPS-1:0]  b_dec_n;

    // ****************************************
    // Phase divider
    // ****************************************
    phase_gen u_phase (
        .clk_sys      (clk_sys),
        .rst          (rst),
        .run          (busy_r),
        .phase_hi_r   (phase_hi),
        .fall_pulse_r (fall_p),
        .rise_pulse_r (rise_p)
    );

    // ****************************************
    // Chip decoders
    // ****************************************
    // A output enable
    chip_decoder #(.SEL_W(3), .OUT_N(`RX_A_CHIPS)) u_adec (
        .clk_sys (clk_sys),
        .rst     (rst),
        .en      (busy_r),
        .sel     (a_r[`RX_A_BITS-1:`RX_CHIP_LO]),
        .sel_n_r (a_dec_n)
    );
    chip_decoder #(.SEL_W(2), .OUT_N(`RX_BC_CHIPS)) u_bdec (
        .clk_sys (clk_sys),
        .rst     (rst),
        .en      (busy_r && (state_r == ST_SRC)),
        .sel     (b_r[`RX_BC_BITS-1:`RX_CHIP_LO]),
        .sel_n_r (b_dec_n)
    );
    chip_decoder #(.SEL_W(2), .OUT_N(`RX_BC_CHIPS)) u_cdec (
        .clk_sys (clk_sys),
        .rst     (rst),
        .en      ((state_r == ST_WR) && !wr_s2_r
                  && (c_r[`RX_BC_BITS-1:`RX_CHIP_LO] != `RX_ROM_CHIP)),
        .sel     (c_r[`RX_BC_BITS-1:`RX_CHIP_LO]),
        .sel_n_r (we_dec_n)
    );

    // ****************************************
    // Sequencer
    // ****************************************
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (start) begin
                    state_nxt = ST_SRC;
                end
            end
            ST_SRC: begin
                if (fall_p) begin
                    state_nxt = ST_DST;
                end
            end
            ST_DST: begin
                if (settle_r == `RX_SETTLE_CYC) begin
                    state_nxt = ST_WR;
                end
            end
            ST_WR: begin
                if (rise_p) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always @(posedge clk_sys) begin
        if (rst) begin
            state_r            <= ST_IDLE;
            a_r                <= {`RX_A_BITS{1'b0}};
            b_r                <= {`RX_BC_BITS{1'b0}};
            c_r                <= {`RX_BC_BITS{1'b0}};
            settle_r           <= {`RX_CNT_W{1'b0}};
            wr_s1_r            <= 1'b1;
            wr_s2_r            <= 1'b1;
            busy_r             <= 1'b0;
            done_r             <= 1'b0;
            phase_out_r        <= 1'b1;
            a_word_r           <= {`RX_WORD_BITS{1'b0}};
            a_oe_n_r           <= {`RX_A_CHIPS{1'b1}};
            ram_addr_r         <= {`RX_WORD_BITS{1'b0}};
            b_oe_n_r           <= {`RX_BC_CHIPS{1'b1}};
            src_latch_r        <= 1'b0;
            instr_enable_low_r <= 1'b1;
            c_we_n_r           <= {`RX_BC_CHIPS{1'b1}};
        end else begin
            state_r     <= state_nxt;
            wr_s1_r     <= slice_write_n;
            wr_s2_r     <= wr_s1_r;
            done_r      <= 1'b0;
            src_latch_r <= 1'b0;
            phase_out_r <= phase_hi;
            a_oe_n_r    <= a_dec_n;
            b_oe_n_r    <= b_dec_n;
            c_we_n_r    <= we_dec_n;
            if (state_r == ST_IDLE && start) begin
                busy_r <= 1'b1;
                a_r    <= a_field;
                b_r    <= b_field;
                c_r    <= two_addr ? b_field : c_field;
            end
            a_word_r <= a_r[`RX_WORD_BITS-1:0];
            case (state_r)
                ST_SRC: begin
                    ram_addr_r         <= b_r[`RX_WORD_BITS-1:0];
                    instr_enable_low_r <= 1'b1;
                    settle_r           <= {`RX_CNT_W{1'b0}};
                    if (fall_p) begin
                        src_latch_r <= 1'b1;
                    end
                end
                ST_DST: begin
                    ram_addr_r <= c_r[`RX_WORD_BITS-1:0];
                    settle_r   <= settle_r + 4'h1;
                end
                ST_WR: begin
                    instr_enable_low_r <= 1'b0;
                    if (rise_p) begin
                        instr_enable_low_r <= 1'b1;
                        busy_r             <= 1'b0;
                        done_r             <= 1'b1;
                    end
                end
                default: begin
                    instr_enable_low_r <= 1'b1;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// [tb/regx_ctrl_checker.sv]
// Port assertions for the store controller
`timescale 1ns/1ps
`default_nettype none
module regx_ctrl_checker (
    input wire logic       clk_sys,
    input wire logic       rst,
    input wire logic       start,
    input wire logic       two_addr,
    input wire logic [6:0] a_field,
    input wire logic [5:0] b_field,
    input wire logic [5:0] c_field,
    input wire logic       slice_write_n,
    input wire logic       busy_r,
    input wire logic       done_r,
    input wire logic       phase_out_r,
    input wire logic [3:0] a_word_r,
    input wire logic [7:0] a_oe_n_r,
    input wire logic [3:0] ram_addr_r,
    input wire logic [3:0] b_oe_n_r,
    input wire logic       src_latch_r,
    input wire logic       instr_enable_low_r,
    input wire logic [3:0] c_we_n_r
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic [6:0] a_cap;
    logic [5:0] b_cap;
    logic [5:0] c_cap;
    always @(posedge clk_sys) begin
        if (!rst && start && !busy_r) begin
            a_cap <= a_field;
            b_cap <= b_field;
            c_cap <= two_addr ? b_field : c_field;
        end
    end
    property p_a_hot; $onehot0(~a_oe_n_r); endproperty
    a_a_hot: assert property (p_a_hot) else $error("two A enables");
    property p_c_hot; $onehot0(~c_we_n_r); endproperty
    a_c_hot: assert property (p_c_hot) else $error("two writes");
    property p_a_dec; a_oe_n_r != 8'hFF |-> ~a_oe_n_r == (8'h01 << a_cap[6:4]); endproperty
    a_a_dec: assert property (p_a_dec) else $error("A chip wrong");
    property p_b_dec; b_oe_n_r != 4'hF |-> ~b_oe_n_r == (4'h1 << b_cap[5:4]); endproperty
    a_b_dec: assert property (p_b_dec) else $error("B chip wrong");
    property p_c_dec; c_we_n_r != 4'hF |-> ~c_we_n_r == (4'h1 << c_cap[5:4]); endproperty
    a_c_dec: assert property (p_c_dec) else $error("C chip wrong");
    property p_dst; src_latch_r |-> ##[1:2] ram_addr_r == c_cap[3:0]; endproperty
    a_dst: assert property (p_dst) else $error("no destination");
    property p_lat; $fell(phase_out_r) |-> ##[0:1] src_latch_r; endproperty
    a_lat: assert property (p_lat) else $error("no latch");
    property p_ien; $fell(instr_enable_low_r) |-> !phase_out_r && ram_addr_r == c_cap[3:0];
    endproperty
    a_ien: assert property (p_ien) else $error("early enable");
    property p_src; phase_out_r |-> instr_enable_low_r; endproperty
    a_src: assert property (p_src) else $error("enable low in high phase");
    property p_done; done_r |-> !busy_r && instr_enable_low_r; endproperty
    a_done: assert property (p_done) else $error("busy at done");
    property p_rom_wr; c_we_n_r[3]; endproperty
    a_rom_wr: assert property (p_rom_wr) else $error("write to read-only code");
    cover property (done_r && two_addr);
    cover property (c_we_n_r != 4'hF);
    cover property (src_latch_r);
endmodule
bind regx_ctrl regx_ctrl_checker chk_i (.clk_sys(clk_sys), .rst(rst), .start(start),
    .two_addr(two_addr), .a_field(a_field), .b_field(b_field), .c_field(c_field),
    .slice_write_n(slice_write_n), .busy_r(busy_r), .done_r(done_r),
    .phase_out_r(phase_out_r), .a_word_r(a_word_r), .a_oe_n_r(a_oe_n_r),
    .ram_addr_r(ram_addr_r), .b_oe_n_r(b_oe_n_r), .src_latch_r(src_latch_r),
    .instr_enable_low_r(instr_enable_low_r), .c_we_n_r(c_we_n_r));
`default_nettype wire

// [tb/slice_model.sv]
// Slice write output answering instruction enable
`timescale 1ns/1ps
`default_nettype none
module slice_model (
    input  wire logic clk_sys,
    input  wire logic instr_enable_low_r,
    input  wire logic slow,
    output var  logic slice_write_n
);
    logic [1:0] wait_r;
    initial begin
        slice_write_n = 1'b1;
        wait_r = 2'h0;
    end
    always @(posedge clk_sys) begin
        if (instr_enable_low_r) begin
            wait_r <= 2'h0;
            slice_write_n <= 1'b1;
        end else if (wait_r >= {1'b0, slow}) slice_write_n <= 1'b0;
        else wait_r <= wait_r + 2'h1;
    end
endmodule
`default_nettype wire

// [tb/regx_ctrl_test.sv]
// Self-checking bench for the store controller
`timescale 1ns/1ps
`default_nettype none
module regx_ctrl_test;
    logic       clk_sys, rst, start, two_addr, slow, seen_d;
    logic [6:0] a_field;
    logic [5:0] b_field, c_field;
    logic [7:0] seen_a, seen_b, seen_c;
    wire        slice_write_n, busy_r, done_r, phase_out_r, src_latch_r, instr_enable_low_r;
    wire  [3:0] a_word_r, ram_addr_r, b_oe_n_r, c_we_n_r;
    wire  [7:0] a_oe_n_r;
    int         error_cnt, checks_done, n;
    regx_ctrl DUT (.clk_sys(clk_sys), .rst(rst), .start(start), .two_addr(two_addr),
        .a_field(a_field), .b_field(b_field), .c_field(c_field),
        .slice_write_n(slice_write_n), .busy_r(busy_r), .done_r(done_r),
        .phase_out_r(phase_out_r), .a_word_r(a_word_r), .a_oe_n_r(a_oe_n_r),
        .ram_addr_r(ram_addr_r), .b_oe_n_r(b_oe_n_r), .src_latch_r(src_latch_r),
        .instr_enable_low_r(instr_enable_low_r), .c_we_n_r(c_we_n_r));
    slice_model slice_i (.clk_sys(clk_sys), .instr_enable_low_r(instr_enable_low_r),
        .slow(slow), .slice_write_n(slice_write_n));
    function automatic logic [3:0] sel4(input logic [1:0] s);
        return ~(4'h1 << s);
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("errors %0d checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic run_op(input logic [6:0] a, input logic [5:0] b, c, input logic two);
        int t;
        @(negedge clk_sys);
        a_field = a; b_field = b; c_field = two ? b : c; two_addr = two; start = 1'b1;
        @(negedge clk_sys);
        start = 1'b0;
        {seen_a, seen_b, seen_c, seen_d} = {24'hFFFFFF, 1'b0};
        for (t = 0; t < 80 && !seen_d; t++) begin
            @(negedge clk_sys);
            if (seen_a === 8'hFF && a_oe_n_r !== 8'hFF) seen_a = a_oe_n_r;
            if (seen_b === 8'hFF && b_oe_n_r !== 4'hF) seen_b = {ram_addr_r, b_oe_n_r};
            if (seen_c === 8'hFF && c_we_n_r !== 4'hF) seen_c = {ram_addr_r, c_we_n_r};
            if (a_oe_n_r !== 8'hFF) chk({4'h0, a_word_r}, {4'h0, a[3:0]});
            seen_d = (done_r === 1'b1);
        end
        if (!seen_d) begin
            error_cnt++;
            report_and_stop;
        end
        chk(seen_a, ~(8'h01 << a[6:4]));
        chk(seen_b, {b[3:0], sel4(b[5:4])});
        chk(seen_c, (c_field[5:4] == 2'h3) ? 8'hFF
            : {c_field[3:0], sel4(c_field[5:4])});
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial begin
        {rst, start, two_addr, slow, a_field, b_field, c_field} = {1'b1, 22'h0};
        error_cnt = 0;
        checks_done = 0;
        n = $urandom(25);
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys) rst = 1'b0;
        run_op(7'h7F, 6'h3F, 6'h00, 1'b0);
        run_op(7'h00, 6'h00, 6'h3F, 1'b1);
        slow = 1'b1;
        run_op(7'h35, 6'h2A, 6'h15, 1'b0);
        repeat (24) begin
            slow = 1'($urandom);
            run_op(7'($urandom), 6'($urandom), 6'($urandom), 1'($urandom));
        end
        report_and_stop;
    end
endmodule
`default_nettype wire
